// file: hdl/gtu_pkg.sv
// ****************************************************************
// constants and carriers of the general timer unit
// ****************************************************************
package gtu_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CONFIG    = 8'h00; // timer_config_reg
    localparam logic [7:0] OFS_A_MODE    = 8'h04; // half_a_mode_reg
    localparam logic [7:0] OFS_B_MODE    = 8'h08; // half_b_mode_reg
    localparam logic [7:0] OFS_CONTROL   = 8'h0C; // timer_control_reg
    localparam logic [7:0] OFS_INT_MASK  = 8'h18; // int_mask_reg
    localparam logic [7:0] OFS_RAW_INT   = 8'h1C; // raw_int_status_reg
    localparam logic [7:0] OFS_MASK_INT  = 8'h20; // masked_int_status_reg
    localparam logic [7:0] OFS_INT_CLEAR = 8'h24; // int_clear_reg
    localparam logic [7:0] OFS_A_LOAD    = 8'h28; // half_a_load_reg
    localparam logic [7:0] OFS_B_LOAD    = 8'h2C; // half_b_load_reg
    localparam logic [7:0] OFS_A_MATCH   = 8'h30; // half_a_match_reg
    localparam logic [7:0] OFS_A_PRESC   = 8'h38; // half_a_prescale_reg
    localparam logic [7:0] OFS_B_PRESC   = 8'h3C; // half_b_prescale_reg
    localparam logic [7:0] OFS_A_COUNT   = 8'h48; // half_a_count_reg
    localparam logic [7:0] OFS_B_COUNT   = 8'h4C; // half_b_count_reg

    // ************************************************************
    // configuration and mode codes
    // ************************************************************
    localparam logic [2:0] CFG_JOIN_TIMER = 3'h0; // 32-bit one-shot/periodic
    localparam logic [2:0] CFG_JOIN_CLOCK = 3'h1; // 32-bit real-time clock
    localparam logic [2:0] CFG_SPLIT      = 3'h4; // two separate 16-bit halves
    localparam logic [1:0] MODE_ONE_SHOT  = 2'h1; // half_a_mode_field one-shot
    localparam logic [1:0] MODE_PERIODIC  = 2'h2; // half_a_mode_field periodic

    // ************************************************************
    // reset and load values
    // ************************************************************
    localparam logic [15:0] RST_HALF     = 16'hFFFF;
    localparam logic [7:0]  RST_PRESCALE = 8'h00;
    localparam logic [31:0] RST_MATCH    = 32'hFFFFFFFF;
    localparam logic [31:0] CLOCK_FIRST  = 32'h00000001;
    localparam logic [31:0] COUNT_ZERO   = 32'h00000000;

    // ************************************************************
    // timing: slow clock input rate and tick rate
    // ************************************************************
    localparam int RTC_IN_HZ = 32768;                // 32.768 KHz input
    localparam int TICK_HZ   = 1;                    // 1 Hz count tick
    localparam int RTC_DIV   = RTC_IN_HZ / TICK_HZ;  // input edges per tick

    // control register as laid out in the word, bits 9..0
    typedef struct packed {
        logic       b_stall;   // half_b_stall_enable, bit 9
        logic       b_en;      // half_b enable, bit 8
        logic [1:0] rsv_hi;    // reads zero
        logic       a_trig;    // half_a_trigger_enable, bit 5
        logic       clk_en;    // clock_mode_enable, bit 4
        logic [1:0] rsv_lo;    // reads zero
        logic       a_stall;   // half_a_stall_enable, bit 1
        logic       a_en;      // half_a_enable, bit 0
    } gtu_ctl_t;

    // interrupt flag word, bits 3..0
    typedef struct packed {
        logic       clk_match; // clock match, bit 3
        logic [1:0] rsv;       // reads zero
        logic       a_timeout; // half_a time-out, bit 0
    } gtu_flags_t;

endpackage

// file: hdl/gtu_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// three-stage input synchroniser with agreement filter
// ****************************************************************
module gtu_sync (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    import gtu_pkg::*;

    logic [2:0] stage;      // stage[0] is read only by stage[1]
    logic       next_level; // filtered level
    logic       next_rise;  // one-cycle rising edge

    // a change counts once the second and third stage agree
    always_comb begin
        next_level = level;
        if (stage[1] == stage[2]) begin
            next_level = stage[2];
        end
        next_rise = next_level & ~level;
    end

    // registers only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage <= 3'h0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            stage <= {stage[1:0], pin};
            level <= next_level;
            rise  <= next_rise;
        end
    end
endmodule
`default_nettype wire

// file: hdl/gtu_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// edge divider: one tick per DIV input edges
// ****************************************************************
module gtu_tick_div #(
    parameter int DIV = gtu_pkg::RTC_DIV
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic clear,
    input  wire logic edge_in,
    output logic      tick
);
    import gtu_pkg::*;

    // elaboration check
    if (DIV < 2 || DIV > 65536) begin : g_bad_div
        $error("gtu_tick_div: DIV out of range");
    end

    logic [15:0] edges;      // input edges seen in this period
    logic [15:0] next_edges; // next edge count
    logic        next_tick;  // next tick

    // count edges, wrap and tick on the last one
    always_comb begin
        next_edges = edges;
        next_tick  = 1'b0;
        if (clear) begin
            next_edges = 16'h0000;
        end else if (edge_in) begin
            if (edges == 16'(DIV - 1)) begin
                next_edges = 16'h0000;
                next_tick  = 1'b1;
            end else begin
                next_edges = edges + 16'h0001;
            end
        end
    end

    // registers only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            edges <= 16'h0000;
            tick  <= 1'b0;
        end else begin
            edges <= next_edges;
            tick  <= next_tick;
        end
    end
endmodule
`default_nettype wire

// file: hdl/gtu_timer.sv
// Contract
// RL1: config 0 joined timer, 1 joined clock
// RL2: halves and loads reset to FFFF
// RL3: both prescale registers reset to zero
// RL4: reset leaves timer idle, controls cleared
// RL5: 32-bit load write fills both halves
// RL6: count read returns B high, A low
// RL7: only half A mode selects behaviour
// RL8: count down, reload after zero
// RL9: one-shot stops and clears enable
// RL10: time-out flag sticky until cleared
// RL11: masked time-out follows raw when unmasked
// RL12: one-cycle trigger pulse at zero
// RL13: load write while running reloads counter
// RL14: stall enable freezes counter during stall; the clock-mode count ignores stall
// RL15: clock mode counts up, first load one
// RL16: software puts later clock loads in match
// RL17: slow clock divided to one hertz tick
// RL18: clock match rolls counter to zero
// RL19: clock match flags, masked, interrupt, cleared
// RL20: clock mode enable overrides both stalls; the code overrides only the half A stall, half_b_stall_enable has no effect
// RL21: unit triggers ORed toward converter
// RL22: joined modes use only even capture pin
// RL23: config 4 selects split halves
// RL24: slow clock synchronised, edges divided
`timescale 1ns/1ns
`default_nettype none
module gtu_timer #(
    parameter int OTHER_UNITS = 2,
    parameter int TICK_DIV    = gtu_pkg::RTC_DIV
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   stall_in,
    input  wire logic                   capture_pin_zero,
    input  wire logic [OTHER_UNITS-1:0] other_triggers,
    output logic                        trigger_out,
    output logic                        conv_trigger,
    output logic                        irq
);
    import gtu_pkg::*;

    // elaboration check
    if (OTHER_UNITS < 1) begin : g_bad_units
        $error("gtu_timer: OTHER_UNITS must be at least 1");
    end

    // ************************************************************
    // helper functions
    // ************************************************************

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // true for both joined 32-bit configurations
    function automatic logic joined(input logic [2:0] cfg);
        return (cfg == CFG_JOIN_TIMER) || (cfg == CFG_JOIN_CLOCK);
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [2:0]  config_q;      // timer_config_reg
    logic [1:0]  a_mode;        // half_a_mode_field
    logic [1:0]  b_mode;        // half_b_mode_reg, kept but unused here
    gtu_ctl_t    ctl;           // timer_control_reg
    gtu_flags_t  raw;           // raw_int_status_reg
    gtu_flags_t  mask;          // int_mask_reg
    logic [15:0] a_load;        // half_a_load_reg
    logic [15:0] b_load;        // half_b_load_reg
    logic [31:0] match;         // half_a_match_reg
    logic [7:0]  a_presc;       // half_a_prescale_reg
    logic [7:0]  b_presc;       // half_b_prescale_reg
    logic [31:0] count;         // half B count high, half A count low
    logic        clock_seen;    // clock mode has been selected once

    logic [2:0]  next_config;   // next values
    logic [1:0]  next_a_mode;
    logic [1:0]  next_b_mode;
    gtu_ctl_t    next_ctl;
    gtu_flags_t  next_raw;
    gtu_flags_t  next_mask;
    logic [15:0] next_a_load;
    logic [15:0] next_b_load;
    logic [31:0] next_match;
    logic [7:0]  next_a_presc;
    logic [7:0]  next_b_presc;
    logic [31:0] next_count;
    logic        next_clock_seen;
    logic        next_trigger;
    logic        next_conv;
    logic        next_irq;
    logic        next_ack;
    logic [31:0] next_rdata;

    logic        stall_lvl;     // filtered stall input
    logic        slow_rise;     // filtered rising edge of slow clock
    logic        sec_tick;      // one-hertz tick
    logic        tick_clear;    // holds divider idle outside clock mode

    // ************************************************************
    // input synchronisers and tick divider
    // ************************************************************
    gtu_sync u_stall_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (stall_in),
        .level    (stall_lvl),
        .rise     ()
    );

    // RL22: even pin only
    // RL24: sync slow clock
    gtu_sync u_slow_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (capture_pin_zero),
        .level    (),
        .rise     (slow_rise)
    );

    // RL17: divide to tick
    gtu_tick_div #(
        .DIV (TICK_DIV)
    ) u_tick_div (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (tick_clear),
        .edge_in  (slow_rise),
        .tick     (sec_tick)
    );

    // divider runs only while the clock configuration is selected and half A is enabled
    assign tick_clear = !((config_q == CFG_JOIN_CLOCK) && ctl.a_en);

    // ************************************************************
    // next-state logic: counting, bus, flags
    // ************************************************************
    always_comb begin
        logic        req;
        logic        wr;
        logic        step;
        logic        ev_timeout;
        logic        ev_clock;
        logic [31:0] wv;
        req        = wb_cyc_i && wb_stb_i;
        wr         = req && wb_ack_o && wb_we_i;
        step       = 1'b0;
        ev_timeout = 1'b0;
        ev_clock   = 1'b0;
        wv         = 32'h00000000;

        next_config     = config_q;
        next_a_mode     = a_mode;
        next_b_mode     = b_mode;
        next_ctl        = ctl;
        next_raw        = raw;
        next_mask       = mask;
        next_a_load     = a_load;
        next_b_load     = b_load;
        next_match      = match;
        next_a_presc    = a_presc;
        next_b_presc    = b_presc;
        next_count      = count;
        next_clock_seen = clock_seen;
        next_rdata      = wb_dat_o;

        // RL20: clock enable beats stall
        // RL14: stall freezes count
        step = ctl.a_en && !(ctl.a_stall && stall_lvl && !ctl.clk_en);

        // RL1: joined timer selected
        // RL7: half A mode only
        if (config_q == CFG_JOIN_TIMER && step) begin
            if (count == COUNT_ZERO) begin
                // RL8: reload after zero
                next_count = {b_load, a_load};
                // RL9: one-shot self-stop
                if (a_mode == MODE_ONE_SHOT) begin
                    next_ctl.a_en = 1'b0;
                end
            end else begin
                // RL8: count down
                next_count = count - 32'h00000001;
            end
        end

        // RL15: clock mode up-count
        if (config_q == CFG_JOIN_CLOCK && ctl.a_en && sec_tick) begin
            if (count == match) begin
                // RL18: roll over at match
                next_count = COUNT_ZERO;
                ev_clock   = 1'b1;
            end else begin
                next_count = count + 32'h00000001;
            end
        end

        // read data is latched in the cycle before ack
        if (req && !wb_ack_o) begin
            case (wb_adr_i)
                OFS_CONFIG:    next_rdata = {29'h0, config_q};
                OFS_A_MODE:    next_rdata = {30'h0, a_mode};
                OFS_B_MODE:    next_rdata = {30'h0, b_mode};
                OFS_CONTROL:   next_rdata = {22'h0, ctl};
                OFS_INT_MASK:  next_rdata = {28'h0, mask};
                OFS_RAW_INT:   next_rdata = {28'h0, raw};
                // RL11: masked view
                OFS_MASK_INT:  next_rdata = {28'h0, raw & mask};
                OFS_A_LOAD:    next_rdata = joined(config_q) ? {b_load, a_load}
                                                             : {16'h0, a_load};
                OFS_B_LOAD:    next_rdata = {16'h0, b_load};
                OFS_A_MATCH:   next_rdata = match;
                OFS_A_PRESC:   next_rdata = {24'h0, a_presc};
                OFS_B_PRESC:   next_rdata = {24'h0, b_presc};
                // RL6: joined count view
                OFS_A_COUNT:   next_rdata = joined(config_q) ? count
                                                             : {16'h0, count[15:0]};
                OFS_B_COUNT:   next_rdata = {16'h0, count[31:16]};
                default:       next_rdata = 32'h00000000;
            endcase
        end

        // writes take effect at the edge where ack is seen
        if (wr) begin
            case (wb_adr_i)
                OFS_CONFIG: begin
                    wv          = merge({29'h0, config_q}, wb_dat_i, wb_sel_i);
                    // RL23: split selectable
                    next_config = wv[2:0];
                    // RL15: first clock load
                    if (wv[2:0] == CFG_JOIN_CLOCK && !clock_seen) begin
                        next_count      = CLOCK_FIRST;
                        next_clock_seen = 1'b1;
                    end
                end
                OFS_A_MODE: begin
                    wv          = merge({30'h0, a_mode}, wb_dat_i, wb_sel_i);
                    next_a_mode = wv[1:0];
                end
                OFS_B_MODE: begin
                    wv          = merge({30'h0, b_mode}, wb_dat_i, wb_sel_i);
                    next_b_mode = wv[1:0];
                end
                OFS_CONTROL: begin
                    wv              = merge({22'h0, ctl}, wb_dat_i, wb_sel_i);
                    next_ctl        = wv[9:0];
                    next_ctl.rsv_hi = 2'h0;
                    next_ctl.rsv_lo = 2'h0;
                end
                OFS_INT_MASK: begin
                    wv            = merge({28'h0, mask}, wb_dat_i, wb_sel_i);
                    next_mask     = wv[3:0];
                    next_mask.rsv = 2'h0;
                end
                OFS_INT_CLEAR: begin
                    wv       = merge(32'h0, wb_dat_i, wb_sel_i);
                    // RL10: software clear
                    // RL19: clock flag clear
                    next_raw = raw & ~wv[3:0];
                end
                OFS_A_LOAD: begin
                    wv = merge({b_load, a_load}, wb_dat_i, wb_sel_i);
                    next_a_load = wv[15:0];
                    // RL5: upper half to B
                    if (joined(config_q)) begin
                        next_b_load = wv[31:16];
                    end
                    // RL13: running reload
                    if (config_q == CFG_JOIN_TIMER) begin
                        next_count = wv;
                    end
                end
                OFS_B_LOAD: begin
                    wv          = merge({16'h0, b_load}, wb_dat_i, wb_sel_i);
                    next_b_load = wv[15:0];
                end
                // RL16: later clock loads
                OFS_A_MATCH:   next_match = merge(match, wb_dat_i, wb_sel_i);
                OFS_A_PRESC: begin
                    wv           = merge({24'h0, a_presc}, wb_dat_i, wb_sel_i);
                    next_a_presc = wv[7:0];
                end
                OFS_B_PRESC: begin
                    wv           = merge({24'h0, b_presc}, wb_dat_i, wb_sel_i);
                    next_b_presc = wv[7:0];
                end
                default: begin
                    // read-only or unmapped: write ignored
                    wv = 32'h00000000;
                end
            endcase
        end

        // zero reached: entered this edge from a non-zero count
        ev_timeout = (config_q == CFG_JOIN_TIMER) && step
                     && (next_count == COUNT_ZERO) && (count != COUNT_ZERO);

        // RL10: set wins over clear
        // RL19: clock match raw
        next_raw.a_timeout = next_raw.a_timeout | ev_timeout;
        next_raw.clk_match = next_raw.clk_match | ev_clock;
        next_raw.rsv       = 2'h0;

        // RL12: one-cycle trigger
        next_trigger = ev_timeout && ctl.a_trig;
        // RL21: OR of unit triggers
        next_conv    = next_trigger || (|other_triggers);
        // RL19: masked interrupt line
        next_irq     = |(next_raw & next_mask);
        next_ack     = req && !wb_ack_o;
    end

    // ************************************************************
    // registers
    // ************************************************************
    // RL2: halves reset FFFF
    // RL3: prescale reset zero
    // RL4: idle after reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            config_q     <= CFG_JOIN_TIMER;
            a_mode       <= 2'h0;
            b_mode       <= 2'h0;
            ctl          <= '0;
            raw          <= '0;
            mask         <= '0;
            a_load       <= RST_HALF;
            b_load       <= RST_HALF;
            match        <= RST_MATCH;
            a_presc      <= RST_PRESCALE;
            b_presc      <= RST_PRESCALE;
            count        <= {RST_HALF, RST_HALF};
            clock_seen   <= 1'b0;
            trigger_out  <= 1'b0;
            conv_trigger <= 1'b0;
            irq          <= 1'b0;
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h00000000;
        end else begin
            config_q     <= next_config;
            a_mode       <= next_a_mode;
            b_mode       <= next_b_mode;
            ctl          <= next_ctl;
            raw          <= next_raw;
            mask         <= next_mask;
            a_load       <= next_a_load;
            b_load       <= next_b_load;
            match        <= next_match;
            a_presc      <= next_a_presc;
            b_presc      <= next_b_presc;
            count        <= next_count;
            clock_seen   <= next_clock_seen;
            trigger_out  <= next_trigger;
            conv_trigger <= next_conv;
            irq          <= next_irq;
            wb_ack_o     <= next_ack;
            wb_dat_o     <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// file: tb/gtu_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// port checks of the timer unit
// ****
module gtu_checker #(
    parameter int OTHER_UNITS = 2
) (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic                   wb_ack_o,
    input wire logic [OTHER_UNITS-1:0] other_triggers,
    input wire logic                   trigger_out,
    input wire logic                   conv_trigger,
    input wire logic                   irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic wr; // a bus write in progress
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i;
    a_trig_pulse: assert property (trigger_out |=> !trigger_out) else $error("long trigger");
    a_conv_or: assert property (!$past(rst) |-> conv_trigger == (trigger_out
        || (|$past(other_triggers)))) else $error("converter trigger not an OR");
    a_quiet_start: assert property ($fell(rst) |-> (!trigger_out && !irq) [*8])
        else $error("activity after reset");
    a_reset_idle: assert property (disable iff (1'b0) rst |-> !trigger_out && !irq && !wb_ack_o)
        else $error("output during reset");
    a_irq_hold: assert property (irq && !wr && !$past(wr) |=> irq)
        else $error("irq dropped without write");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // main scenarios reached
    cover property (trigger_out);
    cover property ($rose(irq));
    cover property (conv_trigger && !trigger_out);
endmodule
`default_nettype wire

// file: tb/tb_gtu_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_gtu_timer;
    import gtu_pkg::*;
    logic        core_clk, rst, cyc, stb, we, stall_in, pin, rtc_on, ack, trig, conv, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [1:0]  oth, sc;
    logic [31:0] dat, dat_o, rd;
    int          bad_count, check_count;
    gtu_timer #(.OTHER_UNITS(2), .TICK_DIV(4)) gtu_timer_i (.core_clk(core_clk), .rst(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .stall_in(stall_in),
        .capture_pin_zero(pin), .other_triggers(oth), .trigger_out(trig),
        .conv_trigger(conv), .irq(irq));
    // ****
    // clocks: core and slow input, eight core cycles per slow period
    // ****
    always #25 core_clk = ~core_clk;
    // slow clock, free running once started
    always @(posedge core_clk) begin
        if (rst) begin
            sc  <= 2'h0;
            pin <= 1'b0;
        end else if (rtc_on) begin
            sc <= sc + 2'h1;
            if (sc == 2'h3) pin <= ~pin;
        end
    end
    // ****
    // bus tasks: hold request until ack seen, then release
    // ****
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do @(posedge core_clk); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge core_clk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task chk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check_count++;
        if (rd !== e) begin bad_count++; $display("[ERR] %0t %h got %h", $time, a, rd); end
    endtask
    // wait for trigger (0) or irq (1), bounded
    task wait_ev(input int w);
        int n;
        n = 0;
        do begin @(negedge core_clk); n++; end while (((w == 0) ? trig : irq) !== 1'b1 && n < 400);
        if (n == 400) begin bad_count++; $display("[ERR] %0t no event", $time); end
        @(posedge core_clk);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial begin
        core_clk = 0; rst = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; dat = 0;
        stall_in = 0; rtc_on = 0; oth = 0; bad_count = 0; check_count = 0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(OFS_A_COUNT, 32'hFFFFFFFF);
        chk(OFS_A_LOAD, 32'hFFFFFFFF);
        chk(OFS_B_LOAD, 32'h0000FFFF);
        chk(OFS_A_PRESC, 32'h0);
        chk(OFS_B_PRESC, 32'h0);
        chk(OFS_CONTROL, 32'h0);
        chk(OFS_CONFIG, 32'h0);
        chk(8'h40, 32'h0);
        $display("test reset done");
        wr(OFS_A_MODE, 32'h1); wr(OFS_INT_MASK, 32'h1); wr(OFS_A_LOAD, 32'h3);
        wr(OFS_CONTROL, 32'h21);
        wait_ev(0);
        oth <= 2'h1;
        chk(OFS_RAW_INT, 32'h1);
        oth <= 2'h0;
        chk(OFS_MASK_INT, 32'h1);
        chk(OFS_CONTROL, 32'h20);
        chk(OFS_A_COUNT, 32'h3);
        wr(OFS_INT_CLEAR, 32'h1);
        chk(OFS_RAW_INT, 32'h0);
        $display("test one-shot done");
        wr(OFS_B_MODE, 32'h1); wr(OFS_A_MODE, 32'h2);
        stall_in <= 1'b1;
        wr(OFS_CONTROL, 32'h3); wr(OFS_A_LOAD, 32'h00050007);
        chk(OFS_A_COUNT, 32'h00050007);
        chk(OFS_B_LOAD, 32'h00000005);
        chk(OFS_A_COUNT, 32'h00050007);
        wr(OFS_A_LOAD, 32'h2); wr(OFS_CONTROL, 32'h23);
        stall_in <= 1'b0;
        wait_ev(0);
        wait_ev(0);
        chk(OFS_CONTROL, 32'h23);
        chk(OFS_RAW_INT, 32'h1);
        wr(OFS_CONTROL, 32'h0); wr(OFS_INT_CLEAR, 32'h1);
        $display("test periodic done");
        wr(OFS_CONFIG, 32'h1);
        chk(OFS_A_COUNT, 32'h1);
        wr(OFS_A_MATCH, 32'h3); wr(OFS_INT_MASK, 32'h8);
        stall_in <= 1'b1;
        rtc_on <= 1'b1;
        wr(OFS_CONTROL, 32'h13);
        wait_ev(1);
        chk(OFS_A_COUNT, 32'h0);
        chk(OFS_RAW_INT, 32'h8);
        chk(OFS_MASK_INT, 32'h8);
        wr(OFS_INT_CLEAR, 32'h8);
        chk(OFS_RAW_INT, 32'h0);
        $display("test clock done");
        wr(OFS_CONFIG, 32'h4);
        wr(OFS_A_LOAD, 32'h00090006);
        chk(OFS_A_LOAD, 32'h00000006);
        chk(OFS_B_LOAD, 32'h00000000);
        $display("test split done");
        test_done;
    end
    // ****
    // watchdog
    // ****
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        $display("[ERR] %0t timeout", $time);
        test_done;
    end
endmodule
bind gtu_timer gtu_checker #(.OTHER_UNITS(OTHER_UNITS)) gtu_checker_i (.core_clk(core_clk),
    .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o), .other_triggers(other_triggers), .trigger_out(trigger_out),
    .conv_trigger(conv_trigger), .irq(irq));
`default_nettype wire
